// *** rtl/sccs_pkg.sv ***
package sccs_pkg;

    localparam int unsigned CLOCK_HZ       = 10000000;
    localparam int unsigned NUM_PINS       = 4;

    localparam logic [1:0]  SEL_WAKEUP     = 2'h0;
    localparam logic [1:0]  SEL_SPARE      = 2'h1;
    localparam logic [1:0]  SEL_PLL        = 2'h2;
    localparam logic [1:0]  SEL_DIRECT     = 2'h3;

    localparam logic [3:0]  OFS_SYS_CFG    = 4'h0;
    localparam logic [3:0]  OFS_PLL_CFG    = 4'h4;
    localparam logic [3:0]  OFS_STATUS     = 4'h8;

    localparam int unsigned PRESC_W        = 10;
    localparam int unsigned PLL_INPUT_DIVIDER_FIELD_W         = 4;
    localparam int unsigned PLL_MULTIPLIER_FIELD_W         = 7;
    localparam int unsigned PLL_OUTPUT_DIVIDER_FIELD_W        = 7;
    localparam int unsigned DEN_W          = PLL_INPUT_DIVIDER_FIELD_W + PLL_OUTPUT_DIVIDER_FIELD_W + 2;

    localparam int unsigned POS_PRESC      = 0;
    localparam int unsigned POS_BYPASS     = 10;
    localparam int unsigned POS_OSC_INT    = 11;
    localparam int unsigned POS_PLL_INPUT_DIVIDER_FIELD       = 12;
    localparam int unsigned POS_PLL_MULTIPLIER_FIELD       = 16;
    localparam int unsigned POS_PLL_OUTPUT_DIVIDER_FIELD      = 23;

    localparam logic [1:0]  RST_SEL        = SEL_WAKEUP;
    localparam logic [PRESC_W-1:0] RST_PRESC = 10'h000;

    typedef struct packed {
        logic [PLL_OUTPUT_DIVIDER_FIELD_W-1:0] pll_output_divider_field;
        logic [PLL_MULTIPLIER_FIELD_W-1:0]  pll_multiplier_field;
        logic [PLL_INPUT_DIVIDER_FIELD_W-1:0]  pll_input_divider_field;
        logic               osc_internal;
        logic               oscillator_bypass_bit;
        logic [PRESC_W-1:0] prescaler_divider_field;
    } sccs_pll_cfg_s;

    localparam sccs_pll_cfg_s RST_PLL_CFG = '{7'h00, 7'h00, 4'h0, 1'b0, 1'b1, RST_PRESC};

    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [3:0] sel;
        logic [3:0] adr;
        logic [31:0] dat;
    } sccs_wb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } sccs_wb_rsp_s;

endpackage

// *** rtl/sccs_pin_sync.sv ***
`timescale 1ns/1ps
module sccs_pin_sync (
    input  wire logic                          clock,
    input  wire logic                          rst_b,
    input  wire logic [sccs_pkg::NUM_PINS-1:0] pin,
    output logic      [sccs_pkg::NUM_PINS-1:0] level
);
    import sccs_pkg::*;

    logic [NUM_PINS-1:0] s1_q;
    logic [NUM_PINS-1:0] s2_q;
    logic [NUM_PINS-1:0] s3_q;
    logic [NUM_PINS-1:0] level_q;
    logic [NUM_PINS-1:0] level_d;

    genvar i;
    generate
        for (i = 0; i < NUM_PINS; i++) begin : g_pin
            // level moves only once stages two and three agree
            always_comb begin
                level_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : level_q[i];
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            level_q <= '0;
        end else begin
            s1_q    <= pin;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= level_d;
        end
    end

    assign level = level_q;

endmodule

// *** rtl/sccs_clock_select.sv ***
`timescale 1ns/1ps
// Functional notes
// - select 11: system clock from direct pin
// - direct mode follows input duty cycle
// - select 10, bypass 1: oscillator divided by factor
// - prescaler source: crystal or internal oscillator
// - factor one passes oscillator phases unchanged
// - largest factor 1024 gives slowest clock
// - crystal bypass factor one equals direct drive
// - select 00: system clock from wakeup source
// - select 10, bypass 0: input times N/(P*K2)
module sccs_clock_select (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        direct_clock_input_pin,
    input  wire logic        crystal_input_pin,
    input  wire logic        internal_osc_pin,
    input  wire logic        wakeup_osc_pin,
    output logic             sys_clock_out
);
    import sccs_pkg::*;

    logic [NUM_PINS-1:0]  lvl;
    logic                 s_direct;
    logic                 s_xtal;
    logic                 s_int;
    logic                 s_wake;

    sccs_pin_sync u_sync (
        .clock (clock),
        .rst_b (rst_b),
        .pin   ({wakeup_osc_pin, internal_osc_pin, crystal_input_pin, direct_clock_input_pin}),
        .level (lvl)
    );

    assign s_direct = lvl[0];
    assign s_xtal   = lvl[1];
    assign s_int    = lvl[2];
    assign s_wake   = lvl[3];

    // register file
    logic [1:0]     sel_q;
    logic [1:0]     sel_d;
    sccs_pll_cfg_s  pcfg_q;
    sccs_pll_cfg_s  pcfg_d;
    logic           ack_q;
    logic           ack_d;
    logic [31:0]    rdat_q;
    logic [31:0]    rdat_d;
    logic           sys_q;
    logic           req;
    logic [31:0]    wmask;
    logic [31:0]    wmerge;

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;

    always_comb begin
        sel_d  = sel_q;
        pcfg_d = pcfg_q;
        ack_d  = req;
        rdat_d = rdat_q;
        wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        wmerge = (32'(pcfg_q) & ~wmask) | (wb_dat_i & wmask);
        if (req && wb_we_i) begin
            if (wb_adr_i == OFS_SYS_CFG && wb_sel_i[0]) begin
                sel_d = wb_dat_i[1:0];
            end else if (wb_adr_i == OFS_PLL_CFG) begin
                // bits above the struct are dropped on purpose
                pcfg_d = sccs_pll_cfg_s'(wmerge[$bits(sccs_pll_cfg_s)-1:0]);
            end
        end
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                OFS_SYS_CFG: rdat_d = {30'h0, sel_q};
                OFS_PLL_CFG: rdat_d = 32'(pcfg_q);
                OFS_STATUS:  rdat_d = {27'h0, sys_q, s_wake, s_int, s_xtal, s_direct};
                default:     rdat_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sel_q  <= RST_SEL;
            pcfg_q <= RST_PLL_CFG;
            ack_q  <= 1'b0;
            rdat_q <= 32'h0;
        end else begin
            sel_q  <= sel_d;
            pcfg_q <= pcfg_d;
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // clock generation
    logic               osc;
    logic               osc_prev_q;
    logic               osc_rise;
    logic [PRESC_W-1:0] cnt_q;
    logic [PRESC_W-1:0] cnt_d;
    logic [PRESC_W:0]   half;
    logic [DEN_W-1:0]   den;
    logic [DEN_W:0]     acc_q;
    logic [DEN_W:0]     acc_d;
    logic [DEN_W:0]     acc_add;
    logic               sys_d;
    logic               presc_mode;
    logic               pll_mode;

    assign osc        = pcfg_q.osc_internal ? s_int : s_xtal;
    assign osc_rise   = osc & ~osc_prev_q;
    assign presc_mode = (sel_q == SEL_PLL) && pcfg_q.oscillator_bypass_bit;
    assign pll_mode   = (sel_q == SEL_PLL) && !pcfg_q.oscillator_bypass_bit;
    assign half       = ({1'b0, pcfg_q.prescaler_divider_field} + 11'h001) >> 1;
    assign den        = DEN_W'(({9'h0, pcfg_q.pll_input_divider_field} + 13'h0001)
                        * ({6'h0, pcfg_q.pll_output_divider_field} + 13'h0001));

    always_comb begin
        cnt_d   = cnt_q;
        acc_d   = acc_q;
        acc_add = '0;
        sys_d   = sys_q;
        unique case (sel_q)
            SEL_DIRECT: sys_d = s_direct;
            SEL_PLL: begin
                if (presc_mode) begin
                    if (osc_rise) begin
                        cnt_d = (cnt_q >= pcfg_q.prescaler_divider_field) ? '0 : cnt_q + 10'h001;
                    end
                    if (pcfg_q.prescaler_divider_field == '0) begin
                        sys_d = osc;
                    end else begin
                        sys_d = {1'b0, cnt_d} < half;
                    end
                end else begin
                    // two toggles per output period, at most one toggle a cycle
                    if (osc_rise) begin
                        acc_add = (DEN_W+1)'({pcfg_q.pll_multiplier_field, 1'b0})
                                  + (DEN_W+1)'(2);
                    end
                    if (acc_q >= {1'b0, den}) begin
                        sys_d = ~sys_q;
                        acc_d = acc_q - {1'b0, den} + acc_add;
                    end else begin
                        acc_d = acc_q + acc_add;
                    end
                end
            end
            default: sys_d = s_wake;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            osc_prev_q <= 1'b0;
            cnt_q      <= '0;
            acc_q      <= '0;
            sys_q      <= 1'b0;
        end else begin
            osc_prev_q <= osc;
            cnt_q      <= cnt_d;
            acc_q      <= acc_d;
            sys_q      <= sys_d;
        end
    end

    assign sys_clock_out = sys_q;

    a_direct_follow: assert property (@(posedge clock) disable iff (!rst_b)
        (sel_q == SEL_DIRECT) |=> (sys_q == $past(s_direct)))
        else $error("direct mode clock does not follow pin");

    a_direct_duty: assert property (@(posedge clock) disable iff (!rst_b)
        (sel_q == SEL_DIRECT) ##1 ((sel_q == SEL_DIRECT) && $rose(s_direct))
        |=> $rose(sys_q))
        else $error("direct mode edge not passed");

    a_wake_follow: assert property (@(posedge clock) disable iff (!rst_b)
        (sel_q == SEL_WAKEUP) |=> (sys_q == $past(s_wake)))
        else $error("wakeup mode clock does not follow source");

    a_div_one: assert property (@(posedge clock) disable iff (!rst_b)
        presc_mode && (pcfg_q.prescaler_divider_field == '0) |=> (sys_q == $past(osc)))
        else $error("factor one does not pass oscillator");

    a_xtal_bypass: assert property (@(posedge clock) disable iff (!rst_b)
        presc_mode && !pcfg_q.osc_internal && (pcfg_q.prescaler_divider_field == '0)
        |=> (sys_q == $past(s_xtal)))
        else $error("crystal bypass does not pass input");

    a_osc_source: assert property (@(posedge clock) disable iff (!rst_b)
        presc_mode && pcfg_q.osc_internal && (pcfg_q.prescaler_divider_field == '0)
        |=> (sys_q == $past(s_int)))
        else $error("internal source not selected");

    a_cnt_wrap: assert property (@(posedge clock) disable iff (!rst_b)
        presc_mode && osc_rise && (cnt_q >= pcfg_q.prescaler_divider_field) |=> (cnt_q == '0))
        else $error("prescaler count does not wrap at factor");

    a_cnt_range: assert property (@(posedge clock) disable iff (!rst_b)
        presc_mode && $stable(pcfg_q) && osc_rise && (cnt_q < pcfg_q.prescaler_divider_field)
        |=> (cnt_q == $past(cnt_q) + 10'h001))
        else $error("prescaler count not advancing");

    a_pll_toggle: assert property (@(posedge clock) disable iff (!rst_b)
        pll_mode && (acc_q >= {1'b0, den}) |=> (sys_q != $past(sys_q)))
        else $error("pll output did not toggle");

    a_ack_pulse: assert property (@(posedge clock) disable iff (!rst_b)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule

// *** testbench/sccs_osc_model.sv ***
`timescale 1ns/1ps
module sccs_osc_model (
    output logic direct_clock_input_pin,
    output logic crystal_input_pin,
    output logic internal_osc_pin,
    output logic wakeup_osc_pin
);
    // free-running sources, periods unrelated to the system clock
    initial begin
        direct_clock_input_pin = 1'b0;
        crystal_input_pin      = 1'b0;
        internal_osc_pin       = 1'b0;
        wakeup_osc_pin         = 1'b0;
    end
    // direct source has a one-third duty cycle
    always begin
        #1100 direct_clock_input_pin = 1'b1;
        #530 direct_clock_input_pin = 1'b0;
    end
    always begin
        #510 crystal_input_pin = 1'b1;
        #300 crystal_input_pin = 1'b0;
    end
    always begin
        #620 internal_osc_pin = 1'b1;
        #610 internal_osc_pin = 1'b0;
    end
    always begin
        #1980 wakeup_osc_pin = 1'b1;
        #1990 wakeup_osc_pin = 1'b0;
    end
endmodule

// *** testbench/sccs_clock_select_tb.sv ***
`timescale 1ns/1ps
module sccs_clock_select_tb;
    import sccs_pkg::*;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [3:0]  adr   = 4'h0;
    logic [3:0]  sel   = 4'h0;
    logic [31:0] dat   = 32'h0;
    logic [31:0] dout;
    logic [31:0] rdat;
    logic        ack;
    logic        sys;
    wire  [3:0]  pin;
    int          n_fail    = 0;
    int          tests_run = 0;
    int          rs, hs, rp, hp, e;
    // select, config, source pin, num, den, window
    int          tbl [9][6] = '{
        '{0, 32'h400, 3, 1, 1, 6000},
        '{1, 32'h400, 3, 1, 1, 6000},
        '{3, 32'h400, 0, 1, 1, 4000},
        '{2, 32'h400, 1, 1, 1, 4000},
        '{2, 32'hC02, 2, 1, 3, 6000},
        '{2, 32'h31000, 1, 2, 1, 4000},
        '{2, 32'h800000, 1, 1, 2, 4000},
        '{2, 32'h7FF, 1, 1, 1024, 22000},
        '{2, 32'hC00, 2, 1, 1, 4000}};

    always #50 clock = ~clock;

    sccs_osc_model sccs_osc_model_inst (
        .direct_clock_input_pin (pin[0]),
        .crystal_input_pin      (pin[1]),
        .internal_osc_pin       (pin[2]),
        .wakeup_osc_pin         (pin[3])
    );

    sccs_clock_select sccs_clock_select_inst (
        .clock                  (clock),
        .rst_b                  (rst_b),
        .wb_cyc_i               (cyc),
        .wb_stb_i               (stb),
        .wb_we_i                (we),
        .wb_adr_i               (adr),
        .wb_sel_i               (sel),
        .wb_dat_i               (dat),
        .wb_dat_o               (dout),
        .wb_ack_o               (ack),
        .direct_clock_input_pin (pin[0]),
        .crystal_input_pin      (pin[1]),
        .internal_osc_pin       (pin[2]),
        .wakeup_osc_pin         (pin[3]),
        .sys_clock_out          (sys)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic int near(int s, int x, int t);
        return (s >= x - t && s <= x + t) ? x : s;
    endfunction

    // one classic cycle, entered just after a rising edge
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        @(posedge clock);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        if (n == 20) n_fail++;
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask

    // count rises and high cycles of the output and of one source pin
    task automatic measure(input int w, input int src);
        logic ps, pp;
        rs = 0;
        hs = 0;
        rp = 0;
        hp = 0;
        ps = sys;
        pp = pin[src];
        repeat (w) begin
            @(posedge clock);
            rs += int'(sys & ~ps);
            hs += int'(sys);
            rp += int'(pin[src] & ~pp);
            hp += int'(pin[src]);
            ps = sys;
            pp = pin[src];
        end
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clock);
        n_fail++;
        results;
    end

    initial begin
        repeat (12) @(posedge clock);
        check({30'h0, ack, sys}, 32'h0);
        check(dout, 32'h0);
        rst_b <= 1'b1;
        @(posedge clock);
        wb(1'b0, OFS_SYS_CFG, 32'h0, 4'hF);
        check(rdat, 32'h0);
        wb(1'b0, OFS_PLL_CFG, 32'h0, 4'hF);
        check(rdat, 32'h400);
        wb(1'b1, OFS_PLL_CFG, 32'hFFFFFFFF, 4'h1);
        wb(1'b0, OFS_PLL_CFG, 32'h0, 4'hF);
        check(rdat, 32'h4FF);
        wb(1'b1, OFS_PLL_CFG, 32'hFFFFFFFF, 4'hF);
        wb(1'b0, OFS_PLL_CFG, 32'h0, 4'hF);
        check(rdat, 32'h3FFFFFFF);
        wb(1'b1, 4'hC, 32'h3, 4'hF);
        wb(1'b0, 4'hC, 32'h0, 4'hF);
        check(rdat, 32'h0);
        wb(1'b1, OFS_STATUS, 32'hFFFFFFFF, 4'hF);
        wb(1'b0, OFS_STATUS, 32'h0, 4'hF);
        check(rdat & 32'hFFFFFFE0, 32'h0);
        wb(1'b0, OFS_PLL_CFG, 32'h0, 4'hF);
        check(rdat, 32'h3FFFFFFF);
        wb(1'b0, OFS_SYS_CFG, 32'h0, 4'hF);
        check(rdat, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 9; i++) begin
            wb(1'b1, OFS_PLL_CFG, tbl[i][1], 4'hF);
            wb(1'b1, OFS_SYS_CFG, tbl[i][0], 4'hF);
            repeat (60) @(posedge clock);
            measure(tbl[i][5], tbl[i][2]);
            e = rp * tbl[i][3] / tbl[i][4];
            check(near(rs, e, tbl[i][3]), e);
            if (tbl[i][3] == tbl[i][4]) begin
                check(near(hs, hp, 8), hp);
            end
            $display("test case %0d done", i);
        end
        results;
    end
endmodule
